// >>> asr_host.sv
// Purpose: host side controller for an async x16 static memory with byte lanes
// Assumes: one clock, software port with read data one cycle after the strobe
// Notes: each access is one word; software polls the status register
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module asr_host
   import asr_pkg::*;
#(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16,
   parameter int POWER_WAIT = POWER_CYCLES
) (
   input wire logic SYS_CLK_I, // system clock
   input wire logic RST_B_I, // synchronous reset, low active
   input wire logic [7:0] REG_ADDR_I, // register byte address
   input wire logic [31:0] REG_WDATA_I, // register write data
   input wire logic REG_WR_I, // write strobe
   input wire logic REG_RD_I, // read strobe
   output logic [31:0] REG_RDATA_O, // read data, cycle after strobe
   output logic [ADDR_W-1:0] WORD_ADDR_O, // memory word address
   output logic SELECT_LOW_PIN_O, // first chip enable, low active
   output logic SELECT_HIGH_PIN_O, // second chip enable, high active
   output logic OE_N_O, // output enable, low active
   output logic WE_N_O, // write enable, low active
   output logic UPPER_LANE_SEL_N_O, // upper byte lane, low active
   output logic LOWER_LANE_SEL_N_O, // lower byte lane, low active
   input wire logic [DATA_W-1:0] DATA_LINES_I, // data lines sensed
   output logic [DATA_W-1:0] DATA_LINES_O, // data lines driven
   output logic [DATA_W-1:0] DATA_LINES_OE_N_O // low while host drives
);
   // refuse at elaboration what the lane split and the counter cannot serve
   if (ADDR_W != 20 || DATA_W != 16 || POWER_WAIT < 1 || POWER_WAIT >= (1 << CNT_W)) begin : g_bad
      $error("asr_host: unsupported parameter values");
   end

   typedef struct packed {
      asr_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic wr;
      logic low_en;
      logic up_en;
      logic done;
      logic sel;
      logic oe_n;
      logic we_n;
      logic drive;
      logic [31:0] rd_out;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
   } asr_regs_t;

   asr_regs_t r_ff, nxt_r;
   localparam int SYNC_STAGES = 2; // flops between the data pins and the capture

   always_comb begin
      nxt_r = r_ff;
      nxt_r.din_s1 = DATA_LINES_I;
      nxt_r.din_s2 = r_ff.din_s1;
      nxt_r.rd_out = '0;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            REG_CTRL: nxt_r.rd_out = {28'h0000000, r_ff.up_en, r_ff.low_en, r_ff.wr, 1'b0};
            REG_ADDR: nxt_r.rd_out = {{(32-ADDR_W){1'b0}}, r_ff.addr};
            REG_WDATA: nxt_r.rd_out = {{(32-DATA_W){1'b0}}, r_ff.wdata};
            REG_RDATA: nxt_r.rd_out = {{(32-DATA_W){1'b0}}, r_ff.rdata};
            REG_STATUS: nxt_r.rd_out = {29'h00000000, r_ff.done,
               (r_ff.st != ASR_POWER), (r_ff.st != ASR_IDLE && r_ff.st != ASR_POWER)};
            default: nxt_r.rd_out = '0;
         endcase
         // reading status clears done unless a transfer ends this cycle
         if (REG_ADDR_I == REG_STATUS)
            nxt_r.done = 1'b0;
      end
      // writes to shadow registers are ignored while an access runs
      if (REG_WR_I && r_ff.st == ASR_IDLE) begin
         case (REG_ADDR_I)
            REG_ADDR: nxt_r.addr = REG_WDATA_I[ADDR_W-1:0];
            REG_WDATA: nxt_r.wdata = REG_WDATA_I[DATA_W-1:0];
            REG_CTRL: begin
               nxt_r.wr = REG_WDATA_I[CTRL_WR_BIT];
               nxt_r.low_en = REG_WDATA_I[CTRL_LOW_BIT];
               nxt_r.up_en = REG_WDATA_I[CTRL_UP_BIT];
            end
            default: nxt_r.wr = r_ff.wr;
         endcase
      end
      case (r_ff.st)
         ASR_POWER: begin
            if (r_ff.cnt == CNT_W'(POWER_WAIT - 1))
               nxt_r.st = ASR_IDLE;
            else
               nxt_r.cnt = r_ff.cnt + CNT_W'(1);
         end
         ASR_IDLE: begin
            if (REG_WR_I && REG_ADDR_I == REG_CTRL && REG_WDATA_I[CTRL_GO_BIT]) begin
               nxt_r.cnt = '0;
               // address set up before select falls
               nxt_r.sel = 1'b1;
               if (REG_WDATA_I[CTRL_WR_BIT]) begin
                  nxt_r.st = ASR_WSETUP;
                  nxt_r.oe_n = 1'b1;
               end else begin
                  nxt_r.st = ASR_READ;
                  nxt_r.oe_n = 1'b0;
                  nxt_r.we_n = 1'b1;
               end
            end
         end
         ASR_READ: begin
            if (r_ff.cnt == CNT_W'(READ_CYCLES - 1 + SYNC_STAGES)) begin
               // pins settle after the access time, then still need both sync flops
               nxt_r.rdata = r_ff.din_s2;
               if (!r_ff.low_en)
                  nxt_r.rdata[7:0] = '0;
               if (!r_ff.up_en)
                  nxt_r.rdata[15:8] = '0;
               nxt_r.oe_n = 1'b1;
               nxt_r.sel = 1'b0;
               nxt_r.cnt = '0;
               nxt_r.st = ASR_FLOAT;
            end else begin
               nxt_r.cnt = r_ff.cnt + CNT_W'(1);
            end
         end
         ASR_FLOAT: begin
            // memory output must turn off before anyone drives
            if (r_ff.cnt == CNT_W'(FLOAT_CYCLES)) begin
               nxt_r.st = ASR_IDLE;
               nxt_r.done = 1'b1;
            end else begin
               nxt_r.cnt = r_ff.cnt + CNT_W'(1);
            end
         end
         ASR_WSETUP: begin
            // drive data and lower write enable together, select already low
            nxt_r.drive = 1'b1;
            nxt_r.we_n = 1'b0;
            nxt_r.cnt = '0;
            nxt_r.st = ASR_WPULSE;
         end
         ASR_WPULSE: begin
            // pulse covers float time plus setup in case output was enabled
            if (r_ff.cnt == CNT_W'(WPULSE_CYCLES - 1)) begin
               // write enable rises first and ends the write; data held past it
               nxt_r.we_n = 1'b1;
               nxt_r.st = ASR_WEND;
            end else begin
               nxt_r.cnt = r_ff.cnt + CNT_W'(1);
            end
         end
         ASR_WEND: begin
            nxt_r.drive = 1'b0;
            nxt_r.sel = 1'b0;
            nxt_r.st = ASR_IDLE;
            nxt_r.done = 1'b1;
         end
         default: nxt_r.st = ASR_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         r_ff <= '{st: ASR_POWER, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign REG_RDATA_O = r_ff.rd_out;
   assign WORD_ADDR_O = r_ff.addr;
   assign SELECT_LOW_PIN_O = !r_ff.sel;
   assign SELECT_HIGH_PIN_O = r_ff.sel;
   assign OE_N_O = r_ff.oe_n;
   assign WE_N_O = r_ff.we_n;
   // lanes follow enables only while selected, idle lanes stay high
   assign LOWER_LANE_SEL_N_O = !(r_ff.sel && r_ff.low_en);
   assign UPPER_LANE_SEL_N_O = !(r_ff.sel && r_ff.up_en);
   assign DATA_LINES_O = r_ff.wdata;
   assign DATA_LINES_OE_N_O = {{8{!(r_ff.drive && r_ff.up_en)}}, {8{!(r_ff.drive && r_ff.low_en)}}};
endmodule
`default_nettype wire

// >>> asr_host_chk.sv
// Purpose: pin protocol checks for the async x16 memory host
// Assumes: one clock domain, synchronous low reset
// Notes: a counter mirrors the power wait after reset
`timescale 1ns/10ps
`default_nettype none
module asr_host_chk #(
   parameter int POWER_WAIT = 20
) (
   input wire logic SYS_CLK_I, // clock
   input wire logic RST_B_I, // reset
   input wire logic [19:0] WORD_ADDR_O, // address
   input wire logic SELECT_LOW_PIN_O, // select low
   input wire logic SELECT_HIGH_PIN_O, // select high
   input wire logic OE_N_O, // output enable
   input wire logic WE_N_O, // write enable
   input wire logic LOWER_LANE_SEL_N_O, // lower lane
   input wire logic [15:0] DATA_LINES_O, // data out
   input wire logic [15:0] DATA_LINES_OE_N_O // drive enables
);
   int cnt_ff;
   always_ff @(posedge SYS_CLK_I) begin
      cnt_ff <= !RST_B_I ? 0 : (cnt_ff < POWER_WAIT ? cnt_ff + 1 : cnt_ff);
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   AST_SEL_PAIR: assert property (SELECT_HIGH_PIN_O == !SELECT_LOW_PIN_O)
      else $error("select pins disagree");
   AST_PWR_WAIT: assert property (cnt_ff < POWER_WAIT |-> SELECT_LOW_PIN_O)
      else $error("access during power wait");
   AST_WE_SEL: assert property (!WE_N_O |-> !SELECT_LOW_PIN_O && !(&DATA_LINES_OE_N_O))
      else $error("write strobe without select or data");
   AST_WR_END: assert property ($rose(WE_N_O) |-> !SELECT_LOW_PIN_O &&
      $stable(DATA_LINES_O) && $stable(WORD_ADDR_O) && !(&DATA_LINES_OE_N_O))
      else $error("write end without hold");
   AST_NO_CLASH: assert property (!OE_N_O |-> &DATA_LINES_OE_N_O)
      else $error("host drives during read");
   AST_RD_WE: assert property (!OE_N_O |-> WE_N_O)
      else $error("write strobe in read");
   AST_ADDR: assert property ($fell(SELECT_LOW_PIN_O) |-> $stable(WORD_ADDR_O))
      else $error("address moved at select");
   AST_FLOAT: assert property ($rose(OE_N_O) |-> (&DATA_LINES_OE_N_O) [*2])
      else $error("drive before bus release");
   COV_WR: cover property ($rose(WE_N_O));
   COV_RD: cover property ($rose(OE_N_O));
   COV_LANE: cover property ($fell(SELECT_LOW_PIN_O) && LOWER_LANE_SEL_N_O);
endmodule
bind asr_host asr_host_chk #(.POWER_WAIT(POWER_WAIT)) i_chk (.SYS_CLK_I(SYS_CLK_I),
   .RST_B_I(RST_B_I), .WORD_ADDR_O(WORD_ADDR_O), .SELECT_LOW_PIN_O(SELECT_LOW_PIN_O),
   .SELECT_HIGH_PIN_O(SELECT_HIGH_PIN_O), .OE_N_O(OE_N_O), .WE_N_O(WE_N_O),
   .LOWER_LANE_SEL_N_O(LOWER_LANE_SEL_N_O), .DATA_LINES_O(DATA_LINES_O),
   .DATA_LINES_OE_N_O(DATA_LINES_OE_N_O));
`default_nettype wire

// >>> asr_mem_model.sv
// Purpose: behavioural x16 static memory with byte lanes
// Assumes: zero delay; released bits show the inverse of the last driven value
// Notes: every write stores one flipped bit, which reads correct on the way out
`timescale 1ns/10ps
`default_nettype none
module asr_mem_model (
   input wire logic sel_low_i, // first select, low active
   input wire logic sel_high_i, // second select, high active
   input wire logic oe_n_i, // output enable
   input wire logic we_n_i, // write enable
   input wire logic up_n_i, // upper lane enable
   input wire logic lo_n_i, // lower lane enable
   input wire logic [19:0] addr_i, // word address
   input wire logic [15:0] dq_i, // resolved bus
   output logic [15:0] q_o, // value seen where host floats
   output logic [15:0] en_o // high where memory drives
);
   logic [15:0] mem [logic [19:0]];
   logic [15:0] flip [logic [19:0]]; // one injected upset per stored word
   logic [15:0] rd, last;
   logic armed = 1'b0;
   int wcnt = 0;
   wire logic sel = !sel_low_i && sel_high_i;
   wire logic wr = sel && !we_n_i;
   wire logic rdq = sel && !oe_n_i && we_n_i;
   assign en_o = {{8{rdq && !up_n_i}}, {8{rdq && !lo_n_i}}};
   // reads hand out the corrected word
   always @(addr_i or wcnt) rd = mem.exists(addr_i) ? mem[addr_i] ^ flip[addr_i] : 16'hA5A5;
   always @(en_o or rd) last = (en_o & rd) | (~en_o & last);
   assign q_o = (en_o & rd) | (~en_o & ~last);
   // store at the first rising edge that closes the overlap
   // only a real write interval arms the store; the fall out of unknown at reset does not
   always @(posedge wr) armed = 1'b1;
   always @(negedge wr) begin
      if (armed) begin
         // the upset stays in the array, reads never write back
         flip[addr_i] = 16'h0001 << (wcnt % 16);
         mem[addr_i] = {up_n_i ? rd[15:8] : dq_i[15:8], lo_n_i ? rd[7:0] : dq_i[7:0]} ^ flip[addr_i];
         wcnt++;
         armed = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> asr_pkg.sv
// Purpose: constants and types for the async x16 static memory host controller
// Assumes: 100 MHz system clock, memory pins driven straight from flip-flops
// Notes: timing counts derive from printed times and the clock period
package asr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWER_TO_FIRST_ACCESS_US = 100;
   localparam int STORE_TO_FLOAT_TIME_NS = 5;
   localparam int DATA_SETUP_TO_END_NS = 5;
   localparam int WE_PULSE_NS = 7;
   localparam int READ_ACCESS_NS = 10;
   localparam int OE_FLOAT_NS = 5;
   localparam int POWER_CYCLES =
      (POWER_TO_FIRST_ACCESS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPULSE_NS_RAW = STORE_TO_FLOAT_TIME_NS + DATA_SETUP_TO_END_NS;
   localparam int WPULSE_NS = (WPULSE_NS_RAW > WE_PULSE_NS) ? WPULSE_NS_RAW : WE_PULSE_NS;
   localparam int WPULSE_CYCLES = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int FLOAT_CYCLES = (OE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_WR_BIT = 1;
   localparam int CTRL_LOW_BIT = 2;
   localparam int CTRL_UP_BIT = 3;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_READY_BIT = 1;
   localparam int ST_DONE_BIT = 2;
   typedef enum logic [2:0] {
      ASR_POWER = 3'b000,
      ASR_IDLE = 3'b001,
      ASR_READ = 3'b011,
      ASR_FLOAT = 3'b010,
      ASR_WSETUP = 3'b110,
      ASR_WPULSE = 3'b111,
      ASR_WEND = 3'b101
   } asr_state_t;
endpackage

// >>> tb.sv
// Purpose: register-level test of the async memory host
// Assumes: short power wait, zero-delay memory model
// Notes: status is polled, so access latency is not pinned here
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import asr_pkg::*;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, sl, sh, oe, we, un, ln;
   logic [7:0] ra = 8'h00;
   logic [31:0] wd = 32'h0, rdat, d;
   logic [19:0] wa;
   logic [15:0] ho, hoe, mq, men, dq;
   // ctrl, address, data (expected value on reads)
   logic [39:0] st [11] = '{40'hF000011234, 40'hD000011234, 40'hFFFFFFC3A5, 40'hDFFFFFC3A5,
      40'hD000011234, 40'h700001AB55, 40'hD000011255, 40'hBFFFFF7E00, 40'hDFFFFF7EA5,
      40'h9000011200, 40'h5000010055};
   int failures = 0, n_tests = 0, cyc = 0;
   assign dq = (ho & ~hoe) | (mq & hoe);
   asr_host #(.POWER_WAIT(20)) i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(ra),
      .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .WORD_ADDR_O(wa),
      .SELECT_LOW_PIN_O(sl), .SELECT_HIGH_PIN_O(sh), .OE_N_O(oe), .WE_N_O(we),
      .UPPER_LANE_SEL_N_O(un), .LOWER_LANE_SEL_N_O(ln), .DATA_LINES_I(dq),
      .DATA_LINES_O(ho), .DATA_LINES_OE_N_O(hoe));
   asr_mem_model i_mem (.sel_low_i(sl), .sel_high_i(sh), .oe_n_i(oe), .we_n_i(we),
      .up_n_i(un), .lo_n_i(ln), .addr_i(wa), .dq_i(dq), .q_o(mq), .en_o(men));
   initial forever #5 clk = ~clk;
   task automatic summarize();
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         summarize();
      end
   end
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) {ra, wd, wr} <= {a, v, 1'b1};
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk) {ra, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 1'b0;
      #1 v = rdat;
   endtask
   // one access, then poll until the done flag shows
   task automatic acc(input logic [3:0] c, input logic [19:0] a, input logic [15:0] v);
      wreg(REG_ADDR, {12'h000, a});
      wreg(REG_WDATA, {16'h0000, v});
      wreg(REG_CTRL, {28'h0000000, c});
      d = 32'h0;
      for (int i = 0; i < 20 && d[ST_DONE_BIT] !== 1'b1; i++) rreg(REG_STATUS, d);
      `CHK(d[ST_DONE_BIT], 1'b1)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rreg(REG_STATUS, d);
      `CHK(d[ST_READY_BIT], 1'b0)
      wreg(REG_ADDR, 32'h00000ABC);
      rreg(REG_ADDR, d);
      `CHK(d, 32'h0)
      repeat (30) @(posedge clk);
      rreg(REG_STATUS, d);
      `CHK(d[ST_READY_BIT], 1'b1)
      rreg(8'h20, d);
      `CHK(d, 32'h0)
      foreach (st[k]) begin
         acc(st[k][39:36], st[k][35:16], st[k][15:0]);
         if (!st[k][37]) begin
            rreg(REG_RDATA, d);
            `CHK(d, {16'h0000, st[k][15:0]})
         end
      end
      rreg(REG_ADDR, d);
      `CHK(d, {12'h000, 20'h00001})
      rreg(REG_CTRL, d);
      `CHK(d, 32'h00000004)
      @(posedge clk) rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rreg(REG_STATUS, d);
      `CHK(d[ST_READY_BIT], 1'b0)
      summarize();
   end
endmodule
`default_nettype wire
